/* File: rpsa_pkg.sv */
// Package: register map, field layout, detector states and carrier types for the port status/port_administration bank
package rpsa_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] RPSA_IDX_PAGE = 6'h01;
  localparam logic [5:0] RPSA_IDX_PORT_ISOLATED_FLAG = 6'h02;
  localparam logic [5:0] RPSA_IDX_JAB = 6'h03;
  localparam logic [5:0] RPSA_IDX_PORT_ADMINISTRATION = 6'h04;
  localparam logic [5:0] RPSA_IDX_CHIPID = 6'h05;
  localparam logic [5:0] RPSA_IDX_IRQ_STAT = 6'h08;
  localparam logic [5:0] RPSA_IDX_IRQ_MASK = 6'h09;

  // Bus geometry
  localparam int RPSA_ADDR_W = 8;
  localparam int RPSA_DATA_W = 32;
  localparam int RPSA_PORTS = 12;
  localparam int RPSA_IDX_LSB = 2;

  // Page select field
  localparam logic [1:0] RPSA_PAGE0 = 2'h0;
  localparam logic [1:0] RPSA_PAGE1 = 2'h1;
  localparam logic [1:0] RPSA_PAGE_RST = 2'h0;

  // Field positions
  localparam int RPSA_LAMP_TEST_BIT = 12;
  localparam int RPSA_FOUR_PAIR_BIT = 12;

  // Interrupt status layout
  localparam int RPSA_IRQ_W = 3;
  localparam int RPSA_IRQ_PORT_ISOLATED_FLAG_BIT = 0;
  localparam int RPSA_IRQ_JAB_BIT = 1;
  localparam int RPSA_IRQ_FP_BIT = 2;

  // Reset values
  localparam logic [11:0] RPSA_PORTS_RST = 12'h000;
  localparam logic [2:0] RPSA_IRQ_RST = 3'h0;

  // Four-pair detection: data-valid about five link clocks after bus-active
  localparam logic [3:0] RPSA_FP_CLKS = 4'h5;
  localparam logic [3:0] RPSA_FP_TOL = 4'h1;
  localparam logic [3:0] RPSA_FP_CNT_MAX = 4'hF;
  localparam logic [3:0] RPSA_FP_CNT_RST = 4'h0;

  // Four-pair detector states, Gray along idle-count-armed-done
  typedef enum logic [1:0] {
    RPSA_FP_IDLE = 2'h0,
    RPSA_FP_COUNT = 2'h1,
    RPSA_FP_ARMED = 2'h3,
    RPSA_FP_DONE = 2'h2
  } rpsa_fp_e;

  // Inter-repeater bus observation signals
  typedef struct packed {
    logic interrepeater_busy_n;
    logic interrepeater_data_valid_n;
    logic interrepeater_data_clock;
    logic sfd_seen;
  } rpsa_irb_s;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [RPSA_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [RPSA_DATA_W-1:0] writedata;
  } rpsa_avs_req_s;

endpackage : rpsa_pkg

/* File: rpsa_regs.sv */
// Port status, administration and four-pair detect register bank on Avalon-MM
//
// Notes on behaviour
// - Two-bit page field chooses page zero or one
// - Partition sensed on a port sets its bit
// - Jabber detected on a port sets its bit
// - Reset clears partition and jabber status bits
// - Port_administration bit one disables port, zero enables
// - Port_administration change applies only at network idle
// - Reset leaves every port enabled
// - Lamp test lights partition lamp of disabled ports
// - Data-valid five clocks after busy plus SFD
// - Four-pair flag sticks until a zero is written to its bit or reset
`timescale 1ns/1ps
module rpsa_regs
  import rpsa_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire rpsa_avs_req_s i_avs,
  output logic [RPSA_DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Per-port events from partition and jabber machines
  input wire logic [RPSA_PORTS-1:0] i_port_isolated_flag,
  input wire logic [RPSA_PORTS-1:0] i_port_overlong_tx_flag,
  // Network idle from the repeater state machine
  input wire logic i_net_idle,
  // Inter-repeater bus monitor
  input wire rpsa_irb_s i_irb,
  // Port control
  output logic [RPSA_PORTS-1:0] o_port_off_bits,
  output logic [RPSA_PORTS-1:0] o_isolation_lamp_en,
  output logic o_four_pair_phy_seen,
  // Interrupt
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [5:0] idx; // Word index from the byte address
  logic req; // Any access pending
  logic acc; // Access completes at this edge
  logic wr_acc; // Write completes at this edge
  logic on_page0; // Page-zero registers visible

  assign idx = i_avs.address[RPSA_IDX_LSB +: 6];
  assign req = i_avs.read | i_avs.write;
  assign acc = req & ~o_avs_waitrequest;
  assign wr_acc = acc & i_avs.write;

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [1:0] page_reg, page_next; // Page select
  logic [RPSA_PORTS-1:0] port_isolated_flag_reg, port_isolated_flag_next; // Partition status
  logic [RPSA_PORTS-1:0] jab_reg, jab_next; // Jabber status
  logic [RPSA_PORTS-1:0] port_administration_reg, port_administration_next; // Requested disable bits
  logic lamp_test_reg, lamp_test_next; // Isolation lamp test
  logic [RPSA_PORTS-1:0] off_reg, off_next; // Applied disable bits
  logic [RPSA_PORTS-1:0] lamp_reg, lamp_next; // Lamp enables
  logic fp_seen_reg, fp_seen_next; // Four-pair flag
  logic [RPSA_IRQ_W-1:0] irq_stat_reg, irq_stat_next; // Sticky events
  logic [RPSA_IRQ_W-1:0] irq_mask_reg, irq_mask_next; // Event mask
  logic irq_reg, irq_next; // Interrupt line
  logic wait_reg, wait_next; // Waitrequest
  logic [RPSA_DATA_W-1:0] rdata_reg, rdata_next; // Read data
  rpsa_fp_e fp_state_reg, fp_state_next; // Four-pair detector
  logic [3:0] fp_cnt_reg, fp_cnt_next; // Link clocks since busy
  logic busy_prev_reg; // Previous busy_n level
  logic lclk_prev_reg; // Previous link clock level
  logic fp_set; // Four-pair detection event
  logic busy_fall; // Bus-active assertion
  logic lclk_rise; // Link clock rising
  logic cnt_ok; // Count within tolerance

  assign on_page0 = (page_reg == RPSA_PAGE0);

  ////////////////////////////////////////////////////////////////////////////
  // Four-pair detector: link clock is sampled as a plain input, so edges are
  // seen only while it is much slower than the core clock

  assign busy_fall = busy_prev_reg & ~i_irb.interrepeater_busy_n;
  assign lclk_rise = i_irb.interrepeater_data_clock & ~lclk_prev_reg;
  assign cnt_ok = (fp_cnt_reg >= (RPSA_FP_CLKS - RPSA_FP_TOL)) && (fp_cnt_reg <= (RPSA_FP_CLKS + RPSA_FP_TOL));

  // Next detector state
  always_comb begin
    fp_state_next = fp_state_reg;
    fp_cnt_next = fp_cnt_reg;
    fp_set = 1'b0;
    case (fp_state_reg)
      RPSA_FP_IDLE: begin
        // Wait for bus-active to assert
        if (busy_fall) begin
          fp_state_next = RPSA_FP_COUNT;
          fp_cnt_next = RPSA_FP_CNT_RST;
        end
      end
      RPSA_FP_COUNT: begin
        // Count link clocks until data-valid asserts
        if (i_irb.interrepeater_busy_n) begin
          fp_state_next = RPSA_FP_IDLE;
        end else if (!i_irb.interrepeater_data_valid_n) begin
          fp_state_next = cnt_ok ? RPSA_FP_ARMED : RPSA_FP_DONE;
        end else if (lclk_rise && (fp_cnt_reg != RPSA_FP_CNT_MAX)) begin
          fp_cnt_next = fp_cnt_reg + 4'h1;
        end
      end
      RPSA_FP_ARMED: begin
        // Timing matched; the SFD completes detection
        if (i_irb.sfd_seen) begin
          fp_set = 1'b1;
          fp_state_next = RPSA_FP_DONE;
        end else if (i_irb.interrepeater_busy_n) begin
          fp_state_next = RPSA_FP_IDLE;
        end
      end
      RPSA_FP_DONE: begin
        // One verdict per frame; rearm when the bus goes quiet
        if (i_irb.interrepeater_busy_n) begin
          fp_state_next = RPSA_FP_IDLE;
        end
      end
      default: begin
        fp_state_next = RPSA_FP_IDLE;
      end
    endcase
  end

  // Detector registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fp_state_reg <= RPSA_FP_IDLE;
      fp_cnt_reg <= RPSA_FP_CNT_RST;
      busy_prev_reg <= 1'b1;
      lclk_prev_reg <= 1'b0;
    end else begin
      fp_state_reg <= fp_state_next;
      fp_cnt_reg <= fp_cnt_next;
      busy_prev_reg <= i_irb.interrepeater_busy_n;
      lclk_prev_reg <= i_irb.interrepeater_data_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file next values

  always_comb begin
    page_next = page_reg;
    port_administration_next = port_administration_reg;
    lamp_test_next = lamp_test_reg;
    irq_mask_next = irq_mask_reg;
    // Partition and jabber bits only ever set by the machines; bus writes have no path
    port_isolated_flag_next = port_isolated_flag_reg | i_port_isolated_flag;
    jab_next = jab_reg | i_port_overlong_tx_flag;
    fp_seen_next = fp_seen_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_acc) begin
      // Reserved bits are not stored, so software need not mask them
      if (idx == RPSA_IDX_PAGE) begin
        page_next = i_avs.writedata[1:0];
      end else if (on_page0 && (idx == RPSA_IDX_PORT_ADMINISTRATION)) begin
        port_administration_next = i_avs.writedata[RPSA_PORTS-1:0];
        lamp_test_next = i_avs.writedata[RPSA_LAMP_TEST_BIT];
      end else if (on_page0 && (idx == RPSA_IDX_CHIPID) && !i_avs.writedata[RPSA_FOUR_PAIR_BIT]) begin
        fp_seen_next = 1'b0; // Writing zero clears the flag
      end else if (idx == RPSA_IDX_IRQ_STAT) begin
        irq_stat_next = irq_stat_reg & ~i_avs.writedata[RPSA_IRQ_W-1:0];
      end else if (idx == RPSA_IDX_IRQ_MASK) begin
        irq_mask_next = i_avs.writedata[RPSA_IRQ_W-1:0];
      end
    end
    // Set wins over a clear in the same cycle
    if (fp_set) begin
      fp_seen_next = 1'b1;
    end
    if (|(i_port_isolated_flag & ~port_isolated_flag_reg)) begin
      irq_stat_next[RPSA_IRQ_PORT_ISOLATED_FLAG_BIT] = 1'b1;
    end
    if (|(i_port_overlong_tx_flag & ~jab_reg)) begin
      irq_stat_next[RPSA_IRQ_JAB_BIT] = 1'b1;
    end
    if (fp_set && !fp_seen_reg) begin
      irq_stat_next[RPSA_IRQ_FP_BIT] = 1'b1;
    end
    // Disable requests reach the ports only when the network is idle
    off_next = i_net_idle ? port_administration_reg : off_reg;
    // Lamp test lights disabled ports
    lamp_next = lamp_test_reg ? off_reg : RPSA_PORTS_RST;
    irq_next = |(irq_stat_reg & irq_mask_reg);
  end

  // Register file flops; reset clears status and enables every port
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      page_reg <= RPSA_PAGE_RST;
      port_isolated_flag_reg <= RPSA_PORTS_RST;
      jab_reg <= RPSA_PORTS_RST;
      port_administration_reg <= RPSA_PORTS_RST;
      lamp_test_reg <= 1'b0;
      off_reg <= RPSA_PORTS_RST;
      lamp_reg <= RPSA_PORTS_RST;
      fp_seen_reg <= 1'b0;
      irq_stat_reg <= RPSA_IRQ_RST;
      irq_mask_reg <= RPSA_IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      page_reg <= page_next;
      port_isolated_flag_reg <= port_isolated_flag_next;
      jab_reg <= jab_next;
      port_administration_reg <= port_administration_next;
      lamp_test_reg <= lamp_test_next;
      off_reg <= off_next;
      lamp_reg <= lamp_next;
      fp_seen_reg <= fp_seen_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait cycle, then the access completes

  always_comb begin
    wait_next = ~(req & wait_reg);
    rdata_next = rdata_reg;
    if (req && wait_reg) begin
      rdata_next = '0;
      // Page one holds only the page and interrupt registers here
      if (idx == RPSA_IDX_PAGE) begin
        rdata_next[1:0] = page_reg;
      end else if (on_page0 && (idx == RPSA_IDX_PORT_ISOLATED_FLAG)) begin
        rdata_next[RPSA_PORTS-1:0] = port_isolated_flag_reg;
      end else if (on_page0 && (idx == RPSA_IDX_JAB)) begin
        rdata_next[RPSA_PORTS-1:0] = jab_reg;
      end else if (on_page0 && (idx == RPSA_IDX_PORT_ADMINISTRATION)) begin
        rdata_next[RPSA_PORTS-1:0] = port_administration_reg;
        rdata_next[RPSA_LAMP_TEST_BIT] = lamp_test_reg;
      end else if (on_page0 && (idx == RPSA_IDX_CHIPID)) begin
        rdata_next[RPSA_FOUR_PAIR_BIT] = fp_seen_reg;
      end else if (idx == RPSA_IDX_IRQ_STAT) begin
        rdata_next[RPSA_IRQ_W-1:0] = irq_stat_reg;
      end else if (idx == RPSA_IDX_IRQ_MASK) begin
        rdata_next[RPSA_IRQ_W-1:0] = irq_mask_reg;
      end
    end
  end

  // Bus flops
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_avs_waitrequest = wait_reg;
  assign o_avs_readdata = rdata_reg;
  assign o_port_off_bits = off_reg;
  assign o_isolation_lamp_en = lamp_reg;
  assign o_four_pair_phy_seen = fp_seen_reg;
  assign o_irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_page_wr;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (wr_acc && idx == RPSA_IDX_PAGE) |=> (page_reg == $past(i_avs.writedata[1:0]));
  endproperty
  a_page_wr: assert property (p_page_wr) else $error("page write not stored");

  property p_page1_hide;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (req && wait_reg && page_reg == RPSA_PAGE1 && idx == RPSA_IDX_PORT_ISOLATED_FLAG) |=> (o_avs_readdata == '0);
  endproperty
  a_page1_hide: assert property (p_page1_hide) else $error("page one shows page zero status");

  property p_port_isolated_flag_set;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      ##1 ((port_isolated_flag_reg & $past(i_port_isolated_flag)) == $past(i_port_isolated_flag));
  endproperty
  a_port_isolated_flag_set: assert property (p_port_isolated_flag_set) else $error("partition event not recorded");

  property p_jab_set;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      ##1 ((jab_reg & $past(i_port_overlong_tx_flag)) == $past(i_port_overlong_tx_flag));
  endproperty
  a_jab_set: assert property (p_jab_set) else $error("jabber event not recorded");

  property p_status_keep;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      ##1 (((port_isolated_flag_reg & $past(port_isolated_flag_reg)) == $past(port_isolated_flag_reg)) && ((jab_reg & $past(jab_reg)) == $past(jab_reg)));
  endproperty
  a_status_keep: assert property (p_status_keep) else $error("status bit cleared without reset");

  property p_off_hold;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      !i_net_idle |=> $stable(o_port_off_bits);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("port state changed outside idle");

  property p_off_apply;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_net_idle |=> (o_port_off_bits == $past(port_administration_reg));
  endproperty
  a_off_apply: assert property (p_off_apply) else $error("idle did not apply port_administration bits");

  property p_lamp;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      lamp_test_reg |=> (o_isolation_lamp_en == $past(o_port_off_bits));
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp test not following disabled ports");

  property p_fp_set;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (fp_state_reg == RPSA_FP_ARMED && i_irb.sfd_seen) |=> o_four_pair_phy_seen && (irq_stat_reg[RPSA_IRQ_FP_BIT] || $past(fp_seen_reg));
  endproperty
  a_fp_set: assert property (p_fp_set) else $error("four-pair flag not set");

  property p_fp_stick;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_four_pair_phy_seen && !(wr_acc && idx == RPSA_IDX_CHIPID)) |=> o_four_pair_phy_seen;
  endproperty
  a_fp_stick: assert property (p_fp_stick) else $error("four-pair flag dropped");

  property p_wait_ack;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("bus answer timing wrong");

endmodule : rpsa_regs

/* File: testbench.sv */
// Self-checking testbench for the port status, administration and four-pair detect register bank
`timescale 1ns/1ps
module testbench;
  import rpsa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Signals
  logic i_core_clk; // 200 MHz core clock
  logic i_rst_n; // Async reset, active low
  rpsa_avs_req_s i_avs; // Bus request
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic [11:0] i_port_isolated_flag;
  logic [11:0] i_port_overlong_tx_flag;
  logic i_net_idle;
  rpsa_irb_s i_irb; // Inter-repeater bus observation
  logic [11:0] o_port_off_bits;
  logic [11:0] o_isolation_lamp_en;
  logic o_four_pair_phy_seen;
  logic o_irq;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd; // Last read word

  rpsa_regs rpsa_regs_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_avs(i_avs),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_port_isolated_flag(i_port_isolated_flag), .i_port_overlong_tx_flag(i_port_overlong_tx_flag),
    .i_net_idle(i_net_idle), .i_irb(i_irb), .o_port_off_bits(o_port_off_bits),
    .o_isolation_lamp_en(o_isolation_lamp_en), .o_four_pair_phy_seen(o_four_pair_phy_seen), .o_irq(o_irq));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the whole run needs well under 2000 cycles
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer; request held until waitrequest is sampled low, a hang is left to the cycle guard
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    @(posedge i_core_clk);
    i_avs.address <= {idx, 2'h0};
    i_avs.write <= wr;
    i_avs.read <= ~wr;
    i_avs.writedata <= d;
    do begin
      @(posedge i_core_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata; // Read data taken at the answering edge
    i_avs.read <= 1'b0;
    i_avs.write <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rchk

  // Let a few edges pass; outputs read at an edge are those launched before it, inputs change at it
  task automatic settle(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk({o_port_off_bits, o_isolation_lamp_en, o_four_pair_phy_seen, o_irq}, 32'h0);
    rchk(RPSA_IDX_PAGE, 32'h0);
    rchk(RPSA_IDX_PORT_ISOLATED_FLAG, 32'h0);
    rchk(RPSA_IDX_JAB, 32'h0);
    rchk(RPSA_IDX_PORT_ADMINISTRATION, 32'h0);
    rchk(RPSA_IDX_CHIPID, 32'h0);
    $display("TEST reset done");
  endtask : t_reset

  // Pulse partition on edge ports and jabber on middle ports; writes must not disturb the captured bits
  task automatic t_status();
    @(posedge i_core_clk);
    i_port_isolated_flag <= 12'h801;
    i_port_overlong_tx_flag <= 12'h3C0;
    @(posedge i_core_clk);
    i_port_isolated_flag <= 12'h000;
    i_port_overlong_tx_flag <= 12'h000;
    rchk(RPSA_IDX_PORT_ISOLATED_FLAG, 32'h801);
    rchk(RPSA_IDX_JAB, 32'h3C0);
    bus(1'b1, RPSA_IDX_PORT_ISOLATED_FLAG, 32'h0000);
    bus(1'b1, RPSA_IDX_JAB, 32'h0FFF);
    rchk(RPSA_IDX_PORT_ISOLATED_FLAG, 32'h801);
    rchk(RPSA_IDX_JAB, 32'h3C0);
    $display("TEST status done");
  endtask : t_status

  // Every page code; only page zero shows the status bank, unmapped reads zero
  task automatic t_page();
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, RPSA_IDX_PAGE, {30'h0, 2'(p)});
      rchk(RPSA_IDX_PAGE, {30'h0, 2'(p)});
      rchk(RPSA_IDX_PORT_ISOLATED_FLAG, (p == 0) ? 32'h801 : 32'h0);
    end
    bus(1'b1, RPSA_IDX_PAGE, {30'h0, RPSA_PAGE0});
    rchk(6'h0F, 32'h0);
    $display("TEST page done");
  endtask : t_page

  // Disable bits wait for network idle; lamp test mirrors disabled ports
  task automatic t_port_administration();
    bus(1'b1, RPSA_IDX_PORT_ADMINISTRATION, 32'h1A5A);
    rchk(RPSA_IDX_PORT_ADMINISTRATION, 32'h1A5A);
    settle(3);
    chk(o_port_off_bits, 32'h0);
    @(posedge i_core_clk);
    i_net_idle <= 1'b1;
    settle(3);
    chk(o_port_off_bits, 32'hA5A);
    chk(o_isolation_lamp_en, 32'hA5A);
    i_net_idle <= 1'b0;
    bus(1'b1, RPSA_IDX_PORT_ADMINISTRATION, 32'h0000);
    settle(3);
    chk(o_port_off_bits, 32'hA5A);
    i_net_idle <= 1'b1;
    settle(3);
    chk({o_port_off_bits, o_isolation_lamp_en}, 32'h0);
    $display("TEST port_administration done");
  endtask : t_port_administration

  // Bus active, n data-clock rising edges, then data valid and frame delimiter
  task automatic fp_try(input int n);
    @(posedge i_core_clk);
    i_irb.interrepeater_busy_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      settle(1);
      i_irb.interrepeater_data_clock <= 1'b1;
      settle(2);
      i_irb.interrepeater_data_clock <= 1'b0;
      settle(1);
    end
    i_irb.interrepeater_data_valid_n <= 1'b0;
    settle(2);
    i_irb.sfd_seen <= 1'b1;
    settle(3);
    i_irb.sfd_seen <= 1'b0;
    i_irb.interrepeater_busy_n <= 1'b1;
    i_irb.interrepeater_data_valid_n <= 1'b1;
    settle(3);
  endtask : fp_try

  task automatic t_fourpair();
    fp_try(2);
    chk(o_four_pair_phy_seen, 32'h0);
    fp_try(5);
    chk(o_four_pair_phy_seen, 32'h1);
    settle(20);
    chk(o_four_pair_phy_seen, 32'h1);
    rchk(RPSA_IDX_CHIPID, 32'h1000);
    bus(1'b1, RPSA_IDX_CHIPID, 32'h0000);
    settle(1);
    chk(o_four_pair_phy_seen, 32'h0);
    // Outside the tolerance on the late side, then the early edge of it
    fp_try(7);
    chk(o_four_pair_phy_seen, 32'h0);
    fp_try(4);
    chk(o_four_pair_phy_seen, 32'h1);
    // Writing the flag bit as one leaves it set
    bus(1'b1, RPSA_IDX_CHIPID, 32'h1000);
    settle(1);
    chk(o_four_pair_phy_seen, 32'h1);
    $display("TEST fourpair done");
  endtask : t_fourpair

  // Sticky status, mask gating, write-one-to-clear
  task automatic t_irq();
    chk(o_irq, 32'h0);
    rchk(RPSA_IDX_IRQ_STAT, 32'h7);
    bus(1'b1, RPSA_IDX_IRQ_MASK, 32'h4);
    settle(2);
    chk(o_irq, 32'h1);
    bus(1'b1, RPSA_IDX_IRQ_STAT, 32'h4);
    rchk(RPSA_IDX_IRQ_STAT, 32'h3);
    settle(2);
    chk(o_irq, 32'h0);
    $display("TEST irq done");
  endtask : t_irq

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////
  // Main sequence; reset held sixteen cycles
  initial begin
    i_rst_n = 1'b0;
    i_avs = '0;
    i_port_isolated_flag = 12'h000;
    i_port_overlong_tx_flag = 12'h000;
    i_net_idle = 1'b0;
    i_irb = '{1'b1, 1'b1, 1'b0, 1'b0};
    repeat (15) @(posedge i_core_clk);
    #1;
    chk(o_avs_waitrequest, 32'h1);
    @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    settle(1);
    t_reset();
    t_status();
    t_page();
    t_port_administration();
    t_fourpair();
    t_irq();
    results();
  end

endmodule : testbench
